// ---- chgsup_pkg.sv ----
package chgsup_pkg;

  // Clock and time base.
  localparam int CLK_PERIOD_NS = 4;
  localparam int CLK_KHZ = 1000000 / CLK_PERIOD_NS;
  localparam int MS_TICK_CYC = CLK_KHZ;

  // APB register byte offsets.
  localparam logic [7:0] OFF_CHARGE_OPTION = 8'h00;
  localparam logic [7:0] OFF_CHARGE_CURRENT = 8'h04;
  localparam logic [7:0] OFF_CHARGE_VOLTAGE = 8'h08;
  localparam logic [7:0] OFF_ALERT_OPTION = 8'h0c;
  localparam logic [7:0] OFF_ALERT_ENABLE = 8'h10;
  localparam logic [7:0] OFF_ALERT_STATUS = 8'h14;
  localparam logic [7:0] OFF_PROT_OPTION = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1c;

  // Charge option field positions and reset value.
  localparam int INHIBIT_BIT = 0;
  localparam int CALIBRATION_DISCHARGE_MODE_BIT = 5;
  localparam int FREQ_LSB = 8;
  localparam int WDT_LSB = 13;
  localparam logic [15:0] CHARGE_OPTION_RST = 16'h6000;

  // Alert option: width field at [4:3], code 2 gives 10 ms.
  localparam int ALERT_W_LSB = 3;
  localparam logic [1:0] ALERT_W_RST = 2'h2;
  localparam logic [6:0] ALERT_EN_RST = 7'h7f;
  localparam logic [4:0] ALERT_W0_MS = 5'h01;
  localparam logic [4:0] ALERT_W1_MS = 5'h05;
  localparam logic [4:0] ALERT_W2_MS = 5'h0a;
  localparam logic [4:0] ALERT_W3_MS = 5'h14;

  // Protection option bits.
  localparam int INPUT_OVERCURRENT_TRIP_MULT_BIT = 9;
  localparam int INPUT_OVERCURRENT_TRIP_DIS_BIT = 10;

  // Switching frequency codes and periods in clock cycles.
  localparam int FSW_600_KHZ = 600;
  localparam int FSW_800_KHZ = 800;
  localparam int FSW_1000_KHZ = 1000;
  localparam logic [1:0] FREQ_800 = 2'h0;
  localparam logic [1:0] FREQ_600 = 2'h1;
  localparam logic [1:0] FREQ_1000 = 2'h2;
  localparam logic [8:0] PER_600_LAST = 9'(CLK_KHZ / FSW_600_KHZ - 1);
  localparam logic [8:0] PER_800_LAST = 9'(CLK_KHZ / FSW_800_KHZ - 1);
  localparam logic [8:0] PER_1000_LAST = 9'(CLK_KHZ / FSW_1000_KHZ - 1);

  // Dead time, rounded up to whole cycles.
  localparam int DEAD_NS = 20;
  localparam logic [2:0] DEAD_LAST = 3'((DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1);

  // Ramp floor voltage in mV.
  localparam logic [7:0] RAMP_START_MV = 8'hc8;

  // Watchdog periods in ms; code 0 disables.
  localparam logic [17:0] WDT_5S_MS = 18'h01388;
  localparam logic [17:0] WDT_88S_MS = 18'h157c0;
  localparam logic [17:0] WDT_175S_MS = 18'h2ab98;

  // Protection timing in ms.
  localparam logic [4:0] INPUT_OVERCURRENT_TRIP_BLANK_MS = 5'h0c;
  localparam logic [4:0] OVP_LIMIT_MS = 5'h1e;
  localparam logic [4:0] BATLOW_HOLD_MS = 5'h01;

  // Current levels in mA.
  localparam logic [15:0] BATLOW_ILIM_MA = 16'h01f4;
  localparam logic [15:0] OCP_MID_FROM_MA = 16'h1000;
  localparam logic [15:0] OCP_HIGH_FROM_MA = 16'h2000;
  localparam logic [1:0] OCP_6A = 2'h0;
  localparam logic [1:0] OCP_9A = 2'h1;
  localparam logic [1:0] OCP_12A = 2'h2;
  localparam logic [3:0] REFRESH_LAST = 4'hf;

  // Analog comparator results, all active high.
  typedef struct packed {
    logic error_amp_above_ramp;
    logic undercurrent_comparator;
    logic below_125ma;
    logic above_250ma;
    logic charge_peak_overcurrent;
    logic input_over_1p25;
    logic input_over_2x;
    logic battery_overvoltage;
    logic battery_low_voltage;
    logic battery_depleted;
  } chgsup_sense_type;

  // Switch and pin drives.
  typedef struct packed {
    logic high_side_switch;
    logic low_side_switch;
    logic ramp_reset;
    logic adapter_switch;
    logic reverse_block_switch;
    logic battery_switch;
    logic discharge_sink;
    logic processor_hot_alert_n;
  } chgsup_drive_type;

  typedef enum logic [2:0] {PS_IDLE, PS_DEAD_HI, PS_HIGH, PS_DEAD_LO, PS_LOW, PS_WAIT} chgsup_pwm_type;

endpackage

// ---- chgsup_top.sv ----
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ns
module chgsup_top import chgsup_pkg::*; #(
  parameter int MS_TICK_CYCLES = MS_TICK_CYC
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog and pin inputs.
  input wire chgsup_sense_type sense,
  input wire logic [6:0] trigger_events,
  input wire logic adapter_detect,
  input wire logic battery_present,
  // Drives to the power stage.
  output chgsup_drive_type drive,
  output logic [1:0] ocp_level,
  output logic [15:0] charge_current_limit,
  output logic [7:0] ramp_floor_mv
);

  logic [17:0] ms_cnt_r;
  logic [15:0] option_r, option_nxt, ichg_r, vchg_r;
  logic [1:0] alert_w_r;
  logic [6:0] alert_en_r, alert_stat_r, alert_stat_nxt;
  logic [1:0] prot_r;
  logic [31:0] prdata_r, rd_mux;
  logic pready_r, pslverr_r;
  logic [17:0] wd_cnt_r;
  logic wd_exp_r;
  logic [4:0] input_overcurrent_trip_cnt_r, ovp_cnt_r, hold_cnt_r, alert_cnt_r;
  logic input_overcurrent_trip_r, ovp_off_r, hold_r, bl_d_r, bp_d_r, nonsync_r, ocp_hold_r, alert_on_r, alert_on_nxt;
  logic [3:0] ref_cnt_r;
  logic [8:0] per_cnt_r;
  logic [2:0] dead_r, dead_nxt;
  chgsup_pwm_type st_r, st_nxt;
  chgsup_drive_type drive_r, drive_nxt;
  logic [1:0] ocp_level_r;
  logic [15:0] ilim_r;

  // Millisecond time base for all long intervals.
  wire ms_tick = ms_cnt_r == 18'(MS_TICK_CYCLES - 1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ms_cnt_r <= '0;
    else ms_cnt_r <= ms_tick ? '0 : ms_cnt_r + 18'h00001;
  end

  // Bus decode; writes take effect at the edge where pready is seen high.
  wire acc_first = psel & penable & ~pready_r;
  wire acc_done = psel & penable & pready_r;
  wire wr = acc_done & pwrite;
  wire sel_opt = paddr == OFF_CHARGE_OPTION;
  wire sel_ichg = paddr == OFF_CHARGE_CURRENT;
  wire sel_vchg = paddr == OFF_CHARGE_VOLTAGE;
  wire sel_aopt = paddr == OFF_ALERT_OPTION;
  wire sel_aen = paddr == OFF_ALERT_ENABLE;
  wire sel_astat = paddr == OFF_ALERT_STATUS;
  wire sel_prot = paddr == OFF_PROT_OPTION;
  wire sel_stat = paddr == OFF_STATUS;
  wire mapped = sel_opt | sel_ichg | sel_vchg | sel_aopt | sel_aen | sel_astat | sel_prot | sel_stat;
  wire wr_opt = wr & sel_opt;
  wire wr_ichg = wr & sel_ichg;
  wire wr_vchg = wr & sel_vchg;

  // Calibration_discharge_mode exit and battery-present edge.
  wire bp_rise = battery_present & ~bp_d_r;
  wire calibration_discharge_mode_exit = option_r[CALIBRATION_DISCHARGE_MODE_BIT] & (sense.battery_depleted | bp_rise);
  wire calibration_discharge_mode_on = option_r[CALIBRATION_DISCHARGE_MODE_BIT] & ~calibration_discharge_mode_exit;

  // Watchdog period select and restart causes.
  wire [1:0] wd_sel = option_r[WDT_LSB +: 2];
  wire [17:0] wd_limit = (wd_sel == 2'h1) ? WDT_5S_MS : (wd_sel == 2'h2) ? WDT_88S_MS : WDT_175S_MS;
  wire wd_restart = wr_ichg | wr_vchg | (wr_opt & (pwdata[WDT_LSB +: 2] != wd_sel));

  // Input overcurrent condition with selectable multiple.
  wire input_overcurrent_trip_cond = ~prot_r[1] & (prot_r[0] ? sense.input_over_2x : sense.input_over_1p25);

  // Converter run conditions.
  wire run = ~option_r[INHIBIT_BIT] & (ichg_r != 16'h0000) & (vchg_r != 16'h0000) & ~wd_exp_r
    & ~input_overcurrent_trip_r & ~ovp_off_r & ~hold_r & drive_r.adapter_switch & adapter_detect;

  // Switching period, frequency select and per-cycle permissions.
  wire [1:0] fsel = option_r[FREQ_LSB +: 2];
  wire [8:0] per_last = (fsel == FREQ_600) ? PER_600_LAST : (fsel == FREQ_1000) ? PER_1000_LAST : PER_800_LAST;
  wire cyc_end = per_cnt_r == per_last;
  wire refresh_slot = ref_cnt_r == 4'h0;
  wire ls_allow = ~nonsync_r & ~sense.below_125ma & ~sense.undercurrent_comparator
    & ~sense.battery_overvoltage
    & (~sense.battery_low_voltage | refresh_slot);
  wire hs_allow = sense.error_amp_above_ramp & ~ocp_hold_r & ~sense.charge_peak_overcurrent
    & ~sense.battery_overvoltage;

  // Alert sources and width threshold.
  wire [6:0] alert_ev = trigger_events & alert_en_r;
  wire alert_any = |alert_ev;
  wire [4:0] alert_w_ms = (alert_w_r == 2'h0) ? ALERT_W0_MS : (alert_w_r == 2'h1) ? ALERT_W1_MS :
    (alert_w_r == 2'h2) ? ALERT_W2_MS : ALERT_W3_MS;

  // Power path: adapter and battery switches never overlap.
  wire adp_want = adapter_detect & ~input_overcurrent_trip_r & ~calibration_discharge_mode_on;

  // Read data selection.
  wire [7:0] status_bits = {alert_on_r, run, option_r[CALIBRATION_DISCHARGE_MODE_BIT], hold_r, nonsync_r, ovp_off_r, input_overcurrent_trip_r, wd_exp_r};
  always_comb begin
    rd_mux = '0;
    if (sel_opt) rd_mux[15:0] = option_r;
    if (sel_ichg) rd_mux[15:0] = ichg_r;
    if (sel_vchg) rd_mux[15:0] = vchg_r;
    if (sel_aopt) rd_mux[ALERT_W_LSB +: 2] = alert_w_r;
    if (sel_aen) rd_mux[6:0] = alert_en_r;
    if (sel_astat) rd_mux[6:0] = alert_stat_r;
    if (sel_prot) rd_mux[INPUT_OVERCURRENT_TRIP_DIS_BIT:INPUT_OVERCURRENT_TRIP_MULT_BIT] = prot_r;
    if (sel_stat) rd_mux[7:0] = status_bits;
  end

  // Bus answer: one wait state, then pready for one cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      pready_r <= acc_first;
      pslverr_r <= acc_first & ~mapped;
      prdata_r <= (acc_first & ~pwrite) ? rd_mux : '0;
    end
  end

  // Charge option next value; hardware calibration_discharge_mode exit beats a same-cycle write.
  always_comb begin
    option_nxt = wr_opt ? pwdata[15:0] : option_r;
    if (calibration_discharge_mode_exit) option_nxt[CALIBRATION_DISCHARGE_MODE_BIT] = 1'b0;
  end

  // Software-written registers; the watchdog never touches them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      option_r <= CHARGE_OPTION_RST;
      ichg_r <= '0;
      vchg_r <= '0;
      alert_w_r <= ALERT_W_RST;
      alert_en_r <= ALERT_EN_RST;
      prot_r <= '0;
    end else begin
      option_r <= option_nxt;
      if (wr_ichg) ichg_r <= pwdata[15:0];
      if (wr_vchg) vchg_r <= pwdata[15:0];
      if (wr & sel_aopt) alert_w_r <= pwdata[ALERT_W_LSB +: 2];
      if (wr & sel_aen) alert_en_r <= pwdata[6:0];
      if (wr & sel_prot) prot_r <= pwdata[INPUT_OVERCURRENT_TRIP_DIS_BIT:INPUT_OVERCURRENT_TRIP_MULT_BIT];
    end
  end

  // Watchdog: counts ms since the last restart and stops conversion on expiry.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_cnt_r <= '0;
      wd_exp_r <= 1'b0;
    end else if (wd_restart || wd_sel == 2'h0) begin
      wd_cnt_r <= '0;
      wd_exp_r <= 1'b0;
    end else if (ms_tick && !wd_exp_r) begin
      wd_cnt_r <= wd_cnt_r + 18'h00001;
      wd_exp_r <= wd_cnt_r == wd_limit - 18'h00001;
    end
  end

  // Input overcurrent: blanking count, then a latch cleared only by adapter removal.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_overcurrent_trip_cnt_r <= '0;
      input_overcurrent_trip_r <= 1'b0;
    end else if (!adapter_detect) begin
      input_overcurrent_trip_cnt_r <= '0;
      input_overcurrent_trip_r <= 1'b0;
    end else begin
      if (!input_overcurrent_trip_cond) input_overcurrent_trip_cnt_r <= '0;
      else if (ms_tick && input_overcurrent_trip_cnt_r != INPUT_OVERCURRENT_TRIP_BLANK_MS + 5'h01) input_overcurrent_trip_cnt_r <= input_overcurrent_trip_cnt_r + 5'h01;
      if (input_overcurrent_trip_cnt_r == INPUT_OVERCURRENT_TRIP_BLANK_MS + 5'h01) input_overcurrent_trip_r <= 1'b1;
    end
  end

  // Overvoltage persistence; the latch is released by a new charge voltage write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovp_cnt_r <= '0;
      ovp_off_r <= 1'b0;
    end else begin
      if (!sense.battery_overvoltage) ovp_cnt_r <= '0;
      else if (ms_tick && ovp_cnt_r != OVP_LIMIT_MS + 5'h01) ovp_cnt_r <= ovp_cnt_r + 5'h01;
      if (ovp_cnt_r == OVP_LIMIT_MS + 5'h01) ovp_off_r <= 1'b1;
      else if (wr_vchg) ovp_off_r <= 1'b0;
    end
  end

  // Low battery: reset hold after each fall below the threshold, light-load hysteresis, edges.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bl_d_r <= 1'b0;
      bp_d_r <= 1'b0;
      hold_r <= 1'b0;
      hold_cnt_r <= '0;
      nonsync_r <= 1'b0;
    end else begin
      bl_d_r <= sense.battery_low_voltage;
      bp_d_r <= battery_present;
      if (sense.battery_low_voltage && !bl_d_r) begin
        hold_r <= 1'b1;
        hold_cnt_r <= '0;
      end else if (hold_r && ms_tick) begin
        hold_cnt_r <= hold_cnt_r + 5'h01;
        if (hold_cnt_r == BATLOW_HOLD_MS) hold_r <= 1'b0;
      end
      if (sense.below_125ma) nonsync_r <= 1'b1;
      else if (sense.above_250ma) nonsync_r <= 1'b0;
    end
  end

  // Switching cycle sequencer with break-before-make dead time.
  always_comb begin
    st_nxt = st_r;
    dead_nxt = '0;
    if (!run) begin
      st_nxt = PS_IDLE;
    end else begin
      case (st_r)
        PS_IDLE: st_nxt = PS_DEAD_HI;
        PS_DEAD_HI: begin
          if (cyc_end) st_nxt = PS_DEAD_HI;
          else if (dead_r != DEAD_LAST) dead_nxt = dead_r + 3'h1;
          else st_nxt = hs_allow ? PS_HIGH : PS_DEAD_LO;
        end
        PS_HIGH: begin
          if (cyc_end) st_nxt = PS_DEAD_HI;
          else if (!hs_allow) st_nxt = PS_DEAD_LO;
        end
        PS_DEAD_LO: begin
          if (cyc_end) st_nxt = PS_DEAD_HI;
          else if (dead_r != DEAD_LAST) dead_nxt = dead_r + 3'h1;
          else st_nxt = ls_allow ? PS_LOW : PS_WAIT;
        end
        PS_LOW: begin
          if (cyc_end) st_nxt = PS_DEAD_HI;
          else if (!ls_allow) st_nxt = PS_WAIT;
        end
        PS_WAIT: begin
          if (cyc_end) st_nxt = PS_DEAD_HI;
        end
        default: st_nxt = PS_IDLE;
      endcase
    end
  end

  // Period counter, per-cycle overcurrent hold and refresh slot counter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= PS_IDLE;
      dead_r <= '0;
      per_cnt_r <= '0;
      ocp_hold_r <= 1'b0;
      ref_cnt_r <= '0;
    end else begin
      st_r <= st_nxt;
      dead_r <= dead_nxt;
      per_cnt_r <= (cyc_end || !run) ? '0 : per_cnt_r + 9'h001;
      if (cyc_end || !run) ocp_hold_r <= 1'b0;
      else if (sense.charge_peak_overcurrent) ocp_hold_r <= 1'b1;
      if (cyc_end) ref_cnt_r <= (ref_cnt_r == REFRESH_LAST) ? '0 : ref_cnt_r + 4'h1;
    end
  end

  // Alert cycle: status cleared and reloaded at the start, accumulated meanwhile.
  always_comb begin
    alert_on_nxt = alert_on_r;
    alert_stat_nxt = alert_stat_r;
    if (!alert_on_r) begin
      if (alert_any) begin
        alert_on_nxt = 1'b1;
        alert_stat_nxt = alert_ev;
      end
    end else begin
      alert_stat_nxt = alert_stat_r | alert_ev;
      if (alert_cnt_r == alert_w_ms + 5'h01 && !alert_any) alert_on_nxt = 1'b0;
    end
  end

  // Alert width counter in ms.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alert_on_r <= 1'b0;
      alert_stat_r <= '0;
      alert_cnt_r <= '0;
    end else begin
      alert_on_r <= alert_on_nxt;
      alert_stat_r <= alert_stat_nxt;
      if (!alert_on_r) alert_cnt_r <= '0;
      else if (ms_tick && alert_cnt_r != alert_w_ms + 5'h01) alert_cnt_r <= alert_cnt_r + 5'h01;
    end
  end

  // Registered drives to the power stage.
  always_comb begin
    drive_nxt.high_side_switch = st_nxt == PS_HIGH;
    drive_nxt.low_side_switch = st_nxt == PS_LOW;
    drive_nxt.ramp_reset = cyc_end | ~run;
    drive_nxt.adapter_switch = adp_want & ~drive_r.battery_switch;
    drive_nxt.reverse_block_switch = adp_want & ~drive_r.battery_switch;
    drive_nxt.battery_switch = ~adp_want & ~drive_r.adapter_switch;
    drive_nxt.discharge_sink = sense.battery_overvoltage;
    drive_nxt.processor_hot_alert_n = ~alert_on_nxt;
  end

  // Output flops, including overcurrent level and current limit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_r <= 8'h01;
      ocp_level_r <= OCP_6A;
      ilim_r <= '0;
    end else begin
      drive_r <= drive_nxt;
      ocp_level_r <= (ichg_r >= OCP_HIGH_FROM_MA) ? OCP_12A : (ichg_r >= OCP_MID_FROM_MA) ? OCP_9A : OCP_6A;
      ilim_r <= (sense.battery_low_voltage && ichg_r > BATLOW_ILIM_MA) ? BATLOW_ILIM_MA : ichg_r;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign drive = drive_r;
  assign ocp_level = ocp_level_r;
  assign charge_current_limit = ilim_r;
  assign ramp_floor_mv = RAMP_START_MV;

endmodule

// ---- chgsup_assertions.sv ----
`timescale 1ns/1ns
module chgsup_checker import chgsup_pkg::*; #(
  parameter int MS_TICK_CYCLES = MS_TICK_CYC
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Bus handshake.
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Sense inputs and drives.
  input wire chgsup_sense_type sense,
  input wire logic [6:0] trigger_events,
  input wire chgsup_drive_type drive,
  input wire logic [15:0] charge_current_limit,
  input wire logic [7:0] ramp_floor_mv
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [31:0] low_cnt_r;

  // Counts alert low cycles so that a release can be judged against the shortest width.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) low_cnt_r <= 32'h0;
    else if (drive.processor_hot_alert_n) low_cnt_r <= 32'h0;
    else low_cnt_r <= low_cnt_r + 32'h1;
  end

  // Bus answers come one cycle after the access phase starts.
  AST_APB_WAIT: assert property (psel && penable && !pready |=> pready) else $error("bus answer late");
  AST_APB_ERR: assert property (pslverr |-> pready && psel && penable) else $error("error outside answer");
  // Alert behaviour.
  AST_ALERT_CAUSE: assert property ($fell(drive.processor_hot_alert_n) |-> $past(trigger_events) != 7'h00)
    else $error("alert without trigger");
  AST_ALERT_MIN: assert property ($rose(drive.processor_hot_alert_n) |-> low_cnt_r >= MS_TICK_CYCLES)
    else $error("alert pulse too short");
  // Switch sequencing.
  AST_NO_OVERLAP: assert property (!(drive.high_side_switch && drive.low_side_switch))
    else $error("both switches on");
  AST_DEAD_GAP: assert property ($rose(drive.high_side_switch) |-> !$past(drive.low_side_switch, 4))
    else $error("dead time missing");
  AST_UNDERCURRENT: assert property (sense.undercurrent_comparator |=> !drive.low_side_switch)
    else $error("low side on in undercurrent");
  AST_NONSYNC: assert property (sense.below_125ma |=> !drive.low_side_switch)
    else $error("low side on at light load");
  AST_PEAK_OC: assert property (sense.charge_peak_overcurrent |=> !drive.high_side_switch)
    else $error("high side on in overcurrent");
  AST_OVERVOLT: assert property (sense.battery_overvoltage |=> !drive.high_side_switch && !drive.low_side_switch
    && drive.discharge_sink) else $error("overvoltage not blocked");
  AST_LOWBAT: assert property (sense.battery_low_voltage |=> charge_current_limit <= BATLOW_ILIM_MA)
    else $error("low battery limit exceeded");
  AST_RAMP: assert property (ramp_floor_mv == RAMP_START_MV) else $error("ramp floor wrong");
  AST_PATH: assert property (!(drive.battery_switch && drive.adapter_switch))
    else $error("power path overlap");
  // Main scenarios reached.
  COV_ALERT: cover property ($fell(drive.processor_hot_alert_n));
  COV_RAMP: cover property ($rose(drive.ramp_reset));
  COV_BATTERY: cover property ($rose(drive.battery_switch));
endmodule
bind chgsup_top chgsup_checker #(.MS_TICK_CYCLES(MS_TICK_CYCLES)) chgsup_checker_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .sense(sense),
  .trigger_events(trigger_events), .drive(drive), .charge_current_limit(charge_current_limit),
  .ramp_floor_mv(ramp_floor_mv));

// ---- chgsup_host_model.sv ----
`timescale 1ns/1ns
module chgsup_host_model (
  // Clock.
  input wire logic pclk,
  // Bus request.
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [7:0] paddr = 8'h00,
  output logic [31:0] pwdata = 32'h0,
  // Bus answer.
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // One bus transfer; the request holds until the answer edge, then is released.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ---- test_charger_supervisor_logic.sv ----
`timescale 1ns/1ns
module test_charger_supervisor_logic;
  import chgsup_pkg::*;
  localparam int MS = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  chgsup_sense_type sense = '0;
  logic [6:0] trigger_events = 7'h00;
  logic adapter_detect = 1'b1;
  logic battery_present = 1'b0;
  chgsup_drive_type drive;
  logic [1:0] ocp_level;
  logic [15:0] charge_current_limit;
  logic [7:0] ramp_floor_mv;
  int err_count = 0;
  int total_checks = 0;

  // Clock generation.
  always #2 pclk = ~pclk;

  chgsup_top #(.MS_TICK_CYCLES(MS)) chgsup_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sense(sense), .trigger_events(trigger_events), .adapter_detect(adapter_detect),
    .battery_present(battery_present), .drive(drive), .ocp_level(ocp_level),
    .charge_current_limit(charge_current_limit), .ramp_floor_mv(ramp_floor_mv));
  chgsup_host_model chgsup_host_model_inst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // Shared helpers for comparisons, bus access and sense pulses.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    chgsup_host_model_inst.xfer(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    chgsup_host_model_inst.xfer(1'b0, a, 32'h0, r, e);
  endtask
  task automatic pulse(input logic [9:0] m, input int n);
    @(posedge pclk);
    sense <= chgsup_sense_type'(sense | m);
    cyc(n);
    chk(32'(charge_current_limit), (m == 10'h002) ? 32'h1f4 : 32'h2000);
    sense <= chgsup_sense_type'(sense & ~m);
  endtask
  // Measures the spacing of two ramp resets in clock cycles.
  task automatic meas(output int n);
    n = 0;
    while (drive.ramp_reset !== 1'b1) @(posedge pclk);
    @(posedge pclk);
    while (drive.ramp_reset !== 1'b1) begin
      n++;
      @(posedge pclk);
    end
    n++;
  endtask
  task automatic tally_and_finish;
    if (err_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Hang guard.
  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end

  // Main sequence.
  initial begin
    logic [31:0] r;
    logic e;
    int n;
    logic [31:0] cur [3] = '{32'h0fff, 32'h1000, 32'h2000};
    logic [31:0] per [4] = '{32'h138, 32'h1a0, 32'h0fa, 32'h138};
    logic [9:0] msk [6] = '{10'h100, 10'h080, 10'h040, 10'h020, 10'h002, 10'h004};
    logic [31:0] prot [3] = '{32'h400, 32'h200, 32'h000};
    logic [9:0] ov [3] = '{10'h018, 10'h010, 10'h010};
    cyc(4);
    presetn <= 1'b1;
    rd(OFF_CHARGE_OPTION, r);
    chk(r, 32'h6000);
    rd(OFF_ALERT_ENABLE, r);
    chk(r, 32'h7f);
    rd(OFF_ALERT_OPTION, r);
    chk(r, 32'h10);
    chgsup_host_model_inst.xfer(1'b1, 8'h20, 32'hffff, r, e);
    chk(32'(e), 32'h1);
    wr(OFF_ALERT_STATUS, 32'h7f);
    rd(OFF_ALERT_STATUS, r);
    chk(r, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(OFF_CHARGE_CURRENT, cur[i]);
      cyc(2);
      chk(32'(ocp_level), 32'(i));
    end
    wr(OFF_CHARGE_VOLTAGE, 32'h3000);
    @(posedge pclk) sense.error_amp_above_ramp <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(OFF_CHARGE_OPTION, 32'h6000 | (32'(c) << 8));
      meas(n);
      meas(n);
      chk(32'(n), per[c]);
    end
    // Amplifier below the ramp: the low side carries the rest of the cycle, so the pulses below reach it.
    @(posedge pclk) sense.error_amp_above_ramp <= 1'b0;
    cyc(20);
    chk(32'(drive.low_side_switch), 32'h1);
    for (int i = 0; i < 6; i++) pulse(msk[i], 400);
    wr(OFF_CHARGE_VOLTAGE, 32'h3000);
    // Alert width, extension, status and enables.
    @(posedge pclk) trigger_events <= 7'h04;
    @(posedge pclk) trigger_events <= 7'h00;
    cyc(2);
    chk(32'(drive.processor_hot_alert_n), 32'h0);
    rd(OFF_ALERT_STATUS, r);
    chk(r, 32'h04);
    cyc(10 * MS - 8);
    chk(32'(drive.processor_hot_alert_n), 32'h0);
    cyc(3 * MS);
    chk(32'(drive.processor_hot_alert_n), 32'h1);
    @(posedge pclk) trigger_events <= 7'h01;
    cyc(15 * MS);
    chk(32'(drive.processor_hot_alert_n), 32'h0);
    rd(OFF_ALERT_STATUS, r);
    chk(r, 32'h01);
    @(posedge pclk) trigger_events <= 7'h00;
    cyc(4);
    chk(32'(drive.processor_hot_alert_n), 32'h1);
    wr(OFF_ALERT_ENABLE, 32'h7e);
    @(posedge pclk) trigger_events <= 7'h01;
    cyc(8);
    chk(32'(drive.processor_hot_alert_n), 32'h1);
    @(posedge pclk) trigger_events <= 7'h00;
    // Calibration_discharge_mode entry, depletion exit and battery insertion exit.
    wr(OFF_CHARGE_OPTION, 32'h6020);
    cyc(4);
    chk({drive.adapter_switch, drive.reverse_block_switch, drive.battery_switch}, 32'h1);
    pulse(10'h001, 8);
    chk({drive.adapter_switch, drive.reverse_block_switch, drive.battery_switch}, 32'h6);
    rd(OFF_CHARGE_OPTION, r);
    chk(r, 32'h6000);
    wr(OFF_CHARGE_OPTION, 32'h6020);
    cyc(4);
    @(posedge pclk) battery_present <= 1'b1;
    cyc(6);
    chk({drive.adapter_switch, drive.reverse_block_switch, drive.battery_switch}, 32'h6);
    // Input overcurrent: disabled, higher multiple, then a real trip cleared by detect.
    for (int k = 0; k < 3; k++) begin
      wr(OFF_PROT_OPTION, prot[k]);
      pulse(ov[k], 14 * MS);
      chk(32'(drive.adapter_switch), 32'(k != 2));
    end
    @(posedge pclk) adapter_detect <= 1'b0;
    cyc(4);
    adapter_detect <= 1'b1;
    cyc(8);
    chk(32'(drive.adapter_switch), 32'h1);
    // Watchdog at the shortest period.
    wr(OFF_CHARGE_OPTION, 32'h2000);
    cyc(5000 * MS - 20);
    rd(OFF_STATUS, r);
    chk(32'(r[0]), 32'h0);
    cyc(40);
    rd(OFF_STATUS, r);
    chk(32'({r[6], r[0]}), 32'h1);
    rd(OFF_CHARGE_VOLTAGE, r);
    chk(r, 32'h3000);
    wr(OFF_CHARGE_CURRENT, 32'h2000);
    rd(OFF_STATUS, r);
    chk(32'(r[0]), 32'h0);
    tally_and_finish();
  end
endmodule
